// file: design/fmt_hdr_pkg.sv
// constants shared by both ends of the format parameter link
// assumes one 100 MHz clock and a byte-wide data-out stream
package fmt_hdr_pkg;
    // header layout
    localparam int header_bytes = 4;
    localparam int descriptor_bytes = 8;
    localparam int options_valid_bit = 7;
    localparam int skip_factory_bit = 6;
    localparam int no_certify_bit = 5;
    localparam int halt_on_error_bit = 4;
    localparam int vendor_bit_pos = 0;
    // defect list format codes
    localparam logic [2:0] format_bytes_from_index = 3'h4;
    localparam logic [2:0] format_physical = 3'h5;
    localparam logic [2:0] format_vendor = 3'h6;
    localparam logic [2:0] format_reserved = 3'h7;
    // sense key and code answers
    localparam logic [7:0] sense_none = 8'h00;
    localparam logic [7:0] sense_illegal = 8'h05;
    localparam logic [7:0] code_none = 8'h00;
    localparam logic [7:0] code_bad_cdb = 8'h24;
    localparam logic [7:0] code_bad_param = 8'h26;
    // list selection bits of the format plan
    localparam int use_factory = 0;
    localparam int use_grown = 1;
    localparam int use_initiator = 2;
    localparam int purge_grown = 3;
    // register offsets of the host controller
    localparam logic [7:0] reg_command = 8'h00;
    localparam logic [7:0] reg_header = 8'h04;
    localparam logic [7:0] reg_descriptor_hi = 8'h08;
    localparam logic [7:0] reg_descriptor_lo = 8'h0c;
    localparam logic [7:0] reg_status = 8'h10;
    localparam logic [7:0] reg_result = 8'h14;
endpackage

// file: design/fmt_link_if.sv
// byte-wide link between initiator and drive decoder
// assumes both ends run on the same pclk
`timescale 1ns/10ps
`default_nettype none
interface fmt_link_if (
    input wire logic pclk
);
    logic cmd_valid; // command start pulse
    logic [7:0] cdb_byte1; // parameters-follow, replace, format code
    logic data_valid; // data-out byte valid
    logic data_ready; // drive accepts byte
    logic [7:0] data_byte; // data-out byte
    logic done; // command end pulse
    logic check_condition; // error end
    logic [7:0] sense_key; // sense key
    logic [7:0] sense_code; // additional sense code
    modport initiator (
        output cmd_valid, cdb_byte1, data_valid, data_byte,
        input data_ready, done, check_condition, sense_key, sense_code
    );
    modport drive (
        input cmd_valid, cdb_byte1, data_valid, data_byte,
        output data_ready, done, check_condition, sense_key, sense_code
    );
endinterface
`default_nettype wire

// file: design/fmt_drive_decoder.sv
// drive end: decodes format command flags, header and descriptors
// assumes the initiator keeps byte order and holds data until accepted
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module fmt_drive_decoder (
    input wire logic pclk,
    input wire logic presetn,
    fmt_link_if.drive link,
    output logic [3:0] list_plan, // factory, grown, initiator, purge
    output logic halt_on_list_error, // stop on defect list error
    output logic plan_valid, // one-cycle pulse when plan is final
    output logic desc_valid, // one-cycle descriptor pulse
    output logic [23:0] desc_cylinder, // cylinder of defect
    output logic [7:0] desc_head, // head of defect
    output logic [31:0] desc_offset, // bytes from index
    output logic [2:0] list_format // accepted format code
);
    typedef enum logic [2:0] {
        idle_st = 3'b000,
        header_st = 3'b001,
        desc_st = 3'b011,
        decide_st = 3'b010,
        end_st = 3'b110
    } state_type;

    state_type state; // current step
    logic [7:0] flags; // header byte one
    logic [15:0] length; // defect list byte count
    logic [15:0] taken; // descriptor bytes taken
    logic [1:0] hdr_index; // header byte index
    logic [2:0] desc_index; // byte within descriptor
    logic [63:0] desc_shift; // descriptor assembly
    logic follow; // parameters follow
    logic replace; // replace grown list
    logic bad_header; // header reserved byte zero not zero
    logic accept; // byte handshake

    assign accept = link.data_valid && link.data_ready;

    // mode table lookup; returns plan bits, or only bit 4 set (5'h10) when unsupported
    function automatic logic [4:0] mode_plan(input logic pf, input logic rg,
                                             input logic sk, input logic nc);
        logic [4:0] p;
        p = 5'h10;
        if (!pf) begin
            p = 5'h09;
        end else if (!rg && !sk && nc) begin
            p = 5'h03;
        end else if (rg && !sk && nc) begin
            p = 5'h09;
        end else if (!rg && sk && nc) begin
            p = 5'h02;
        end else if (rg && sk && nc) begin
            p = 5'h0c;
        end
        return p;
    endfunction

    // command sequencing and byte collection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= idle_st;
            flags <= 8'h00;
            length <= 16'h0000;
            taken <= 16'h0000;
            hdr_index <= 2'h0;
            desc_index <= 3'h0;
            desc_shift <= 64'h0;
            follow <= 1'b0;
            replace <= 1'b0;
            bad_header <= 1'b0;
            list_format <= 3'h0;
            link.data_ready <= 1'b0;
            desc_valid <= 1'b0;
        end else begin
            desc_valid <= 1'b0;
            case (state)
                idle_st: begin
                    if (link.cmd_valid) begin
                        follow <= link.cdb_byte1[4];
                        replace <= link.cdb_byte1[3];
                        list_format <= link.cdb_byte1[2:0];
                        hdr_index <= 2'h0;
                        bad_header <= 1'b0;
                        flags <= 8'h00;
                        length <= 16'h0000;
                        taken <= 16'h0000;
                        desc_index <= 3'h0;
                        // data-out only when parameters follow
                        if (link.cdb_byte1[4]) begin
                            state <= header_st;
                            link.data_ready <= 1'b1;
                        end else begin
                            state <= decide_st;
                        end
                    end
                end
                header_st: begin
                    if (accept) begin
                        hdr_index <= hdr_index + 2'h1;
                        if (hdr_index == 2'h0 && link.data_byte != 8'h00) begin
                            bad_header <= 1'b1;
                        end
                        if (hdr_index == 2'h1) begin
                            flags <= link.data_byte;
                        end
                        if (hdr_index == 2'h2) begin
                            length[15:8] <= link.data_byte;
                        end
                        if (hdr_index == 2'h3) begin
                            length[7:0] <= link.data_byte;
                            if ({length[15:8], link.data_byte} == 16'h0000) begin
                                link.data_ready <= 1'b0;
                                state <= decide_st;
                            end else begin
                                state <= desc_st;
                            end
                        end
                    end
                end
                desc_st: begin
                    if (accept) begin
                        desc_shift <= {desc_shift[55:0], link.data_byte};
                        desc_index <= desc_index + 3'h1;
                        taken <= taken + 16'h0001;
                        if (desc_index == 3'h7) begin
                            desc_valid <= 1'b1;
                        end
                        if (taken + 16'h0001 == length) begin
                            link.data_ready <= 1'b0;
                            state <= decide_st;
                        end
                    end
                end
                decide_st: begin
                    state <= end_st;
                end
                default: begin
                    state <= idle_st;
                end
            endcase
        end
    end

    // descriptor fields taken from the assembled eight bytes
    assign desc_cylinder = desc_shift[63:40];
    assign desc_head = desc_shift[39:32];
    assign desc_offset = desc_shift[31:0];

    // final plan and command answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            list_plan <= 4'h0;
            halt_on_list_error <= 1'b0;
            plan_valid <= 1'b0;
            link.done <= 1'b0;
            link.check_condition <= 1'b0;
            link.sense_key <= fmt_hdr_pkg::sense_none;
            link.sense_code <= fmt_hdr_pkg::code_none;
        end else begin
            plan_valid <= 1'b0;
            link.done <= 1'b0;
            if (state == decide_st) begin
                logic ov;
                logic sk;
                logic nc;
                logic [4:0] p;
                ov = flags[fmt_hdr_pkg::options_valid_bit];
                // invalid options read as factory on, certify off
                sk = (ov && follow) ? flags[fmt_hdr_pkg::skip_factory_bit] : 1'b0;
                nc = (ov && follow) ? flags[fmt_hdr_pkg::no_certify_bit] : 1'b1;
                p = mode_plan(follow, replace, sk, nc);
                link.done <= 1'b1;
                link.check_condition <= 1'b0;
                link.sense_key <= fmt_hdr_pkg::sense_none;
                link.sense_code <= fmt_hdr_pkg::code_none;
                if (follow && (list_format == fmt_hdr_pkg::format_vendor ||
                        list_format == fmt_hdr_pkg::format_reserved ||
                        (length != 16'h0000 && !list_format[2]))) begin
                    link.check_condition <= 1'b1;
                    link.sense_key <= fmt_hdr_pkg::sense_illegal;
                    link.sense_code <= fmt_hdr_pkg::code_bad_cdb;
                end else if (follow && (bad_header || flags[3:0] != 4'h0 ||
                        (!ov && flags[6:4] != 3'h0) || length[2:0] != 3'h0)) begin
                    link.check_condition <= 1'b1;
                    link.sense_key <= fmt_hdr_pkg::sense_illegal;
                    link.sense_code <= fmt_hdr_pkg::code_bad_param;
                end else if (p[4]) begin
                    link.check_condition <= 1'b1;
                    link.sense_key <= fmt_hdr_pkg::sense_illegal;
                    link.sense_code <= fmt_hdr_pkg::code_bad_param;
                end else begin
                    // initiator list used only when one was sent
                    list_plan <= {p[3], p[2] && length != 16'h0000, p[1:0]};
                    halt_on_list_error <= ov && follow &&
                        flags[fmt_hdr_pkg::halt_on_error_bit];
                    plan_valid <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: design/fmt_initiator.sv
// initiator end: software loads command, header and descriptors over apb
// assumes the drive end answers on the shared link interface
`timescale 1ns/10ps
`default_nettype none
module fmt_initiator (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    fmt_link_if.initiator link
);
    logic [7:0] cmd; // cdb byte one
    logic [31:0] header; // four header bytes, byte zero high
    logic [63:0] desc; // pending descriptor
    logic desc_full; // descriptor waiting to go
    logic busy; // command in flight
    logic [3:0] left; // bytes left in current burst
    logic [63:0] shift; // outgoing bytes
    logic sent_header; // header burst finished
    logic [15:0] result; // last sense key and code
    logic result_err; // last check condition
    logic acc; // apb access phase
    logic start; // software start

    assign acc = psel && penable;
    assign start = acc && pwrite && paddr == fmt_hdr_pkg::reg_command && !busy;

    // apb answers in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= 32'h0;
            if (psel && !penable && !pwrite) begin
                if (paddr == fmt_hdr_pkg::reg_command) begin
                    prdata <= {24'h0, cmd};
                end else if (paddr == fmt_hdr_pkg::reg_header) begin
                    prdata <= header;
                end else if (paddr == fmt_hdr_pkg::reg_status) begin
                    prdata <= {30'h0, desc_full, busy};
                end else if (paddr == fmt_hdr_pkg::reg_result) begin
                    prdata <= {15'h0, result_err, result};
                end else if (paddr != fmt_hdr_pkg::reg_descriptor_hi &&
                        paddr != fmt_hdr_pkg::reg_descriptor_lo) begin
                    pslverr <= 1'b1;
                end
            end else if (psel && !penable && paddr > fmt_hdr_pkg::reg_result) begin
                pslverr <= 1'b1;
            end
        end
    end

    // register writes, byte stream and result capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd <= 8'h00;
            header <= 32'h0;
            desc <= 64'h0;
            desc_full <= 1'b0;
            busy <= 1'b0;
            left <= 4'h0;
            shift <= 64'h0;
            sent_header <= 1'b0;
            result <= 16'h0;
            result_err <= 1'b0;
            link.cmd_valid <= 1'b0;
            link.cdb_byte1 <= 8'h00;
            link.data_valid <= 1'b0;
            link.data_byte <= 8'h00;
        end else begin
            link.cmd_valid <= 1'b0;
            if (acc && pready && pwrite && !busy) begin
                if (paddr == fmt_hdr_pkg::reg_command) begin
                    cmd <= pwdata[7:0];
                end else if (paddr == fmt_hdr_pkg::reg_header) begin
                    header <= pwdata;
                end
            end
            if (acc && pready && pwrite && paddr == fmt_hdr_pkg::reg_descriptor_hi) begin
                desc[63:32] <= pwdata;
            end
            // low word write queues the descriptor
            if (acc && pready && pwrite && paddr == fmt_hdr_pkg::reg_descriptor_lo) begin
                desc[31:0] <= pwdata;
                desc_full <= 1'b1;
            end
            if (start && pready) begin
                busy <= 1'b1;
                sent_header <= 1'b0;
                link.cmd_valid <= 1'b1;
                link.cdb_byte1 <= pwdata[7:0];
                if (pwdata[4]) begin
                    shift <= {header, 32'h0};
                    left <= 4'h4;
                end
            end
            if (busy && left == 4'h0 && desc_full && sent_header && !link.data_valid) begin
                shift <= desc;
                left <= 4'h8;
                desc_full <= 1'b0;
            end
            if (left != 4'h0 && (!link.data_valid || link.data_ready)) begin
                link.data_valid <= 1'b1;
                link.data_byte <= shift[63:56];
                shift <= {shift[55:0], 8'h00};
                left <= left - 4'h1;
                if (left == 4'h1) begin
                    sent_header <= 1'b1;
                end
            end else if (link.data_valid && link.data_ready) begin
                link.data_valid <= 1'b0;
            end
            if (link.done) begin
                busy <= 1'b0;
                link.data_valid <= 1'b0;
                left <= 4'h0;
                result <= {link.sense_key, link.sense_code};
                result_err <= link.check_condition;
            end
        end
    end
endmodule
`default_nettype wire

// file: tb/fmt_link_assertions.sv
// link checker: data handshake, command end and sense answers
// assumes the bench wires it to the signals of the link interface
`timescale 1ns/10ps
`default_nettype none
module fmt_link_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic cmd_valid,
    input wire logic [7:0] cdb_byte1,
    input wire logic data_valid,
    input wire logic data_ready,
    input wire logic [7:0] data_byte,
    input wire logic done,
    input wire logic check_condition,
    input wire logic [7:0] sense_key,
    input wire logic [7:0] sense_code
);
    logic fol; // parameters follow, latched at start
    logic [2:0] fc; // format code, latched at start
    logic [7:0] opt; // header flag byte seen on the wire
    logic [15:0] len; // header length seen on the wire
    logic [16:0] cnt; // bytes taken since start
    logic idx; // whole header seen, bytes-from-index list
    assign idx = fol && fc == fmt_hdr_pkg::format_bytes_from_index && cnt >= 17'h4;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // command fields latched at the start pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fol <= 1'b0;
            fc <= 3'h0;
        end else if (cmd_valid) begin
            fol <= cdb_byte1[4];
            fc <= cdb_byte1[2:0];
        end
    end
    // byte count and header fields; stale fields are masked by the count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 17'h0;
            opt <= 8'h0;
            len <= 16'h0;
        end else if (cmd_valid) begin
            cnt <= 17'h0;
        end else if (data_valid && data_ready) begin
            cnt <= cnt + 17'h1;
            if (cnt == 17'h1) begin
                opt <= data_byte;
            end
            if (cnt == 17'h2) begin
                len[15:8] <= data_byte;
            end
            if (cnt == 17'h3) begin
                len[7:0] <= data_byte;
            end
        end
    end
    property p_hold;
        data_valid && !data_ready && !done |=> data_valid && $stable(data_byte);
    endproperty
    a_hold: assert property (p_hold) else $error("byte changed before accept");
    property p_no_data;
        data_valid && !cmd_valid |-> fol;
    endproperty
    a_no_data: assert property (p_no_data) else $error("data without parameters");
    property p_clean;
        done && !check_condition |-> sense_key == 8'h00 && sense_code == 8'h00;
    endproperty
    a_clean: assert property (p_clean) else $error("sense set on good end");
    property p_key;
        done && check_condition |-> sense_key == fmt_hdr_pkg::sense_illegal;
    endproperty
    a_key: assert property (p_key) else $error("wrong sense key");
    property p_bad_code;
        done && fol && fc[2:1] == 2'b11 |-> check_condition && sense_code == 8'h24;
    endproperty
    a_bad_code: assert property (p_bad_code) else $error("reserved code taken");
    property p_flags;
        done && idx && !opt[7] && opt[6:4] != 3'h0 |-> check_condition && sense_code == 8'h26;
    endproperty
    a_flags: assert property (p_flags) else $error("flags without options taken");
    property p_len;
        done && idx && len[2:0] != 3'h0 |-> check_condition && sense_code == 8'h26;
    endproperty
    a_len: assert property (p_len) else $error("odd list length taken");
    property p_count;
        done && fol && !check_condition |-> cnt == {1'b0, len} + 17'h4;
    endproperty
    a_count: assert property (p_count) else $error("byte count off");
    property p_no_follow_end;
        cmd_valid && !cdb_byte1[4] |-> ##[1:16] done;
    endproperty
    a_no_follow_end: assert property (p_no_follow_end) else $error("no quick end");
endmodule
`default_nettype wire

// file: tb/format_defect_header_decoder_tb_top.sv
// bench: apb software side drives the initiator, the drive decoder answers
// assumes one 100 MHz clock and an active low asynchronous reset
`timescale 1ns/10ps
`default_nettype none
module format_defect_header_decoder_tb_top;
    logic pclk = 1'b0; // bench clock
    logic presetn = 1'b0; // reset, active low
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdv; // read data, last value taken
    logic pready, pslverr, errv, got_chk, halt_on_list_error, plan_valid, desc_valid, got_halt;
    logic [3:0] list_plan, got_plan;
    logic [23:0] desc_cylinder;
    logic [7:0] desc_head, got_key, got_code;
    logic [31:0] desc_offset;
    logic [2:0] list_format, got_fmt;
    int err_count = 0;
    int checks_done = 0;
    bit done_seen, plan_seen; // set by the monitor
    logic [7:0] got_bytes[$];
    logic [63:0] got_desc[$], desc_q[$];
    always #5 pclk = ~pclk;
    fmt_link_if link (.pclk(pclk));
    fmt_initiator fmt_initiator_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
    fmt_drive_decoder fmt_drive_decoder_i (.pclk(pclk), .presetn(presetn), .link(link),
        .list_plan(list_plan), .halt_on_list_error(halt_on_list_error),
        .plan_valid(plan_valid), .desc_valid(desc_valid), .desc_cylinder(desc_cylinder),
        .desc_head(desc_head), .desc_offset(desc_offset), .list_format(list_format));
    fmt_link_assertions fmt_link_assertions_i (.pclk(pclk), .presetn(presetn),
        .cmd_valid(link.cmd_valid), .cdb_byte1(link.cdb_byte1), .data_valid(link.data_valid),
        .data_ready(link.data_ready), .data_byte(link.data_byte), .done(link.done),
        .check_condition(link.check_condition), .sense_key(link.sense_key),
        .sense_code(link.sense_code));
    // record what the link and the drive end present at each edge
    always @(posedge pclk) begin
        if (link.data_valid === 1'b1 && link.data_ready === 1'b1) begin
            got_bytes.push_back(link.data_byte);
        end
        if (plan_valid === 1'b1) begin
            plan_seen = 1'b1;
            got_plan = list_plan;
            got_halt = halt_on_list_error;
            got_fmt = list_format;
        end
        if (desc_valid === 1'b1) begin
            got_desc.push_back({desc_cylinder, desc_head, desc_offset});
        end
        if (link.done === 1'b1) begin
            done_seen = 1'b1;
            got_chk = link.check_condition;
            got_key = link.sense_key;
            got_code = link.sense_code;
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // a wait ran out
    task automatic fail();
        err_count++;
        $display("Error at %0t: wait ran out", $time);
        tally_and_finish();
    endtask
    task automatic cmp(input logic [63:0] got, input logic [63:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // one apb transfer; read data and slave error land in rdv and errv
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (n >= 100) fail();
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // one format command through the registers, checked against the model
    task automatic run(input logic [7:0] cdb, input logic [31:0] hdr, input int nd,
        input string nm);
        logic [7:0] f;
        logic [7:0] code;
        logic [3:0] plan;
        logic [7:0] ex[$];
        int n;
        f = hdr[23:16];
        desc_q.delete();
        for (int i = 0; i < nd; i++) begin
            desc_q.push_back(i == 0 ? {1'b0, 32'($urandom()), 31'($urandom())} :
                desc_q[i - 1] + 64'($urandom_range(1, 4000)));
        end
        got_bytes.delete();
        got_desc.delete();
        done_seen = 1'b0;
        plan_seen = 1'b0;
        apb(1'b1, fmt_hdr_pkg::reg_header, hdr);
        if (nd > 0) begin
            apb(1'b1, fmt_hdr_pkg::reg_descriptor_hi, desc_q[0][63:32]);
            apb(1'b1, fmt_hdr_pkg::reg_descriptor_lo, desc_q[0][31:0]);
        end
        apb(1'b1, fmt_hdr_pkg::reg_command, {24'h0, cdb});
        for (int i = 1; i < nd; i++) begin
            n = 0;
            do begin
                apb(1'b0, fmt_hdr_pkg::reg_status, 32'h0);
                n++;
            end while (rdv[1] !== 1'b0 && !done_seen && n < 200);
            if (n >= 200) fail();
            if (!done_seen) begin
                apb(1'b1, fmt_hdr_pkg::reg_descriptor_hi, desc_q[i][63:32]);
                apb(1'b1, fmt_hdr_pkg::reg_descriptor_lo, desc_q[i][31:0]);
            end
        end
        n = 0;
        while (!done_seen && n < 3000) begin
            @(posedge pclk);
            n++;
        end
        if (!done_seen) fail();
        repeat (2) @(posedge pclk);
        code = 8'h00;
        if (cdb[4] && (cdb[2:1] == 2'b11 || (hdr[15:0] != 16'h0 && !cdb[2]))) begin
            code = fmt_hdr_pkg::code_bad_cdb;
        end else if (cdb[4] && ((!f[7] && f[6:4] != 3'h0) || (f[7] && !f[5]) || hdr[2:0] != 3'h0)) begin
            code = fmt_hdr_pkg::code_bad_param;
        end
        case ({cdb[4], cdb[3], f[7] & f[6]})
            3'b100: plan = 4'h3; // factory and grown
            3'b110: plan = 4'h9; // factory, grown purged
            3'b101: plan = 4'h2; // grown only
            3'b111: plan = {1'b1, hdr[15:0] != 16'h0, 2'b00}; // initiator list, purge
            default: plan = 4'h9; // no parameters: factory, purge
        endcase
        cmp(got_chk, code != 8'h0, "check condition");
        cmp(got_key, code != 8'h0 ? 8'h05 : 8'h00, "sense key");
        cmp(got_code, code, "sense code");
        if (code == 8'h0) begin
            cmp(plan_seen, 1'b1, "plan pulse");
            cmp(got_plan, plan, "list plan");
            cmp(got_halt, cdb[4] & f[7] & f[4], "halt flag");
            if (cdb[4]) begin
                cmp(got_fmt, cdb[2:0], "format code");
                ex = {hdr[31:24], hdr[23:16], hdr[15:8], hdr[7:0]};
            end
            foreach (desc_q[i]) begin
                for (int b = 7; b >= 0; b--) begin
                    ex.push_back(desc_q[i][b * 8 +: 8]);
                end
            end
            cmp(got_bytes.size(), ex.size(), "byte count");
            foreach (ex[i]) cmp(got_bytes[i], ex[i], "wire byte");
            cmp(got_desc.size(), nd, "descriptor count");
            foreach (desc_q[i]) cmp(got_desc[i], desc_q[i], "descriptor");
        end
        apb(1'b0, fmt_hdr_pkg::reg_status, 32'h0);
        cmp(rdv[0], 1'b0, "busy after end");
        $display("test %s ended", nm);
    endtask
    initial begin
        logic [7:0] rc;
        logic [31:0] rh;
        int nd;
        void'($urandom(32'h2dd460a3));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, fmt_hdr_pkg::reg_status, 32'h0);
        cmp(rdv, 32'h0, "status after reset");
        apb(1'b0, 8'h20, 32'h0);
        cmp(errv, 1'b1, "unmapped slave error");
        run(8'h00, 32'h0000_0000, 0, "no parameters");
        run(8'h08, 32'h00f0_0000, 0, "no parameters with flags");
        for (int c = 0; c < 8; c++) begin
            run(8'h10 | 8'(c), 32'h00a0_0000, 0, "format code");
        end
        for (int m = 0; m < 4; m++) begin
            run({4'h1, m[1], 3'h4}, {9'h001, m[0], 6'h20, 16'h0010}, 2, "mode");
        end
        run(8'h14, 32'h0060_0000, 0, "flags without options");
        run(8'h14, 32'h0000_0000, 0, "options clear");
        run(8'h14, 32'h0080_0000, 0, "certify asked");
        run(8'h14, 32'h00b0_0004, 1, "odd length");
        run(8'h10, 32'h00a0_0008, 1, "length without index code");
        run(8'h14, 32'h00b0_0008, 1, "halt on error");
        for (int k = 0; k < 12; k++) begin
            rc = {3'h0, 2'($urandom_range(0, 3)), 3'h4 | 3'($urandom_range(0, 1))};
            nd = (rc[4] && rc[2:0] == 3'h4) ? int'($urandom_range(0, 2)) : 0;
            rh = {8'h00, 4'($urandom_range(0, 15)), 4'h0, 16'(nd * 8)};
            run(rc, rh, nd, "random");
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
